// >>> uhi_pkg.sv
// Purpose: Constants and carriers for the host controller event and pointer block
// Assumes: Plain register port, word offsets of our own, 40 MHz core clock
// Notes: Reset values and bit positions below are shared by the design and its tests
package uhi_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_MASK_SET = 4'h4;
  localparam logic [3:0] OFS_MASK_CLR = 4'h8;
  localparam logic [3:0] OFS_AREA_BASE = 4'hC;
  localparam logic [3:0] OFS_PERIODIC = 4'h3;
  localparam logic [3:0] OFS_OVERRUN_CNT = 4'h7;
  localparam int unsigned BIT_OWNERSHIP = 30;
  localparam int unsigned BIT_ROOT_HUB = 6;
  localparam int unsigned BIT_FRAME_WRAP = 5;
  localparam int unsigned BIT_FATAL = 4;
  localparam int unsigned BIT_RESUME = 3;
  localparam int unsigned BIT_FRAME_BEGIN = 2;
  localparam int unsigned BIT_DONE_WB = 1;
  localparam int unsigned BIT_OVERRUN = 0;
  localparam int unsigned BIT_MASTER = 31;
  localparam logic [31:0] EVENT_BITS = 32'h4000_007F;
  localparam logic [31:0] MASK_BITS = 32'hC000_007F;
  localparam logic [31:0] AREA_BITS = 32'hFFFF_FF00;
  localparam logic [31:0] PERIODIC_BITS = 32'hFFFF_FFF0;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] AREA_RST = 32'h0000_0000;
  localparam logic [31:0] PERIODIC_RST = 32'h0000_0000;
  localparam logic [1:0] OVERRUN_CNT_RST = 2'h0;

  typedef struct packed {
    logic ownership_request;
    logic root_hub_change;
    logic frame_msb;
    logic area_copy_done;
    logic frame_start;
    logic fatal_error;
    logic resume_signal;
    logic resume_by_software;
    logic done_writeback;
    logic schedule_overrun;
    logic error_corrected;
  } uhi_events_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uhi_bus_req_t;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] mask;
    logic [31:0] area_base;
    logic [31:0] periodic;
    logic [1:0] overrun_cnt;
    logic frame_msb_seen;
    logic msb_pending;
    logic resume_seen;
    logic halted;
    logic [31:0] rdata;
  } uhi_state_t;
endpackage : uhi_pkg

// >>> uhi_irq_regs.sv
// Purpose: Event flags, enable mask, master enable and two pointer registers
// Assumes: Event inputs are synchronous to core_clk_i; one cycle read latency
// Notes: Interrupt outputs are levels derived from registered state
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module uhi_irq_regs #(
  parameter bit HAS_SMI_PIN = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire uhi_pkg::uhi_bus_req_t bus_i,
  output logic [31:0] rdata_o,
  input wire uhi_pkg::uhi_events_t events_i,
  input wire logic periodic_update_i,
  input wire logic [31:0] periodic_addr_i,
  output logic host_irq_o,
  output logic system_management_irq_o,
  output logic writeback_allowed_o,
  output logic processing_halt_o,
  output logic [31:0] comm_area_base_o
);
  import uhi_pkg::*;

  uhi_state_t cur;
  uhi_state_t next_cur;
  logic [31:0] set_ev;
  logic [31:0] clr_ev;
  logic [31:0] mask_read;
  logic [31:0] pending;

  always_comb begin
    set_ev = '0;
    set_ev[BIT_OWNERSHIP] = events_i.ownership_request & HAS_SMI_PIN;
    set_ev[BIT_ROOT_HUB] = events_i.root_hub_change;
    set_ev[BIT_FRAME_WRAP] = (cur.msb_pending | (events_i.frame_msb != cur.frame_msb_seen))
                             & events_i.area_copy_done;
    set_ev[BIT_FATAL] = events_i.fatal_error;
    set_ev[BIT_RESUME] = events_i.resume_signal & ~cur.resume_seen
                         & ~events_i.resume_by_software;
    set_ev[BIT_FRAME_BEGIN] = events_i.frame_start & events_i.area_copy_done;
    // A writeback reported in the clearing cycle must keep the flag set
    set_ev[BIT_DONE_WB] = events_i.done_writeback;
    set_ev[BIT_OVERRUN] = events_i.schedule_overrun & events_i.area_copy_done;
  end

  always_comb begin
    clr_ev = '0;
    if (bus_i.wr && bus_i.addr == OFS_FLAGS) begin
      clr_ev = bus_i.wdata & EVENT_BITS;
    end
  end

  assign mask_read = cur.mask & MASK_BITS;
  assign pending = cur.flags & cur.mask & EVENT_BITS;

  always_comb begin
    next_cur = cur;
    // Set beats clear so an event in the clearing cycle is kept
    next_cur.flags = ((cur.flags & ~clr_ev) | set_ev) & EVENT_BITS;
    if (!HAS_SMI_PIN) begin
      next_cur.flags[BIT_OWNERSHIP] = 1'b0;
    end
    if (events_i.frame_msb != cur.frame_msb_seen) begin
      next_cur.frame_msb_seen = events_i.frame_msb;
      next_cur.msb_pending = ~events_i.area_copy_done;
    end else if (events_i.area_copy_done) begin
      next_cur.msb_pending = 1'b0;
    end
    next_cur.resume_seen = events_i.resume_signal;
    if (events_i.schedule_overrun) begin
      next_cur.overrun_cnt = cur.overrun_cnt + 2'd1;
    end
    if (events_i.fatal_error) begin
      next_cur.halted = 1'b1;
    end else if (events_i.error_corrected) begin
      next_cur.halted = 1'b0;
    end
    if (periodic_update_i) begin
      next_cur.periodic = periodic_addr_i & PERIODIC_BITS;
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        OFS_MASK_SET: next_cur.mask = cur.mask | (bus_i.wdata & MASK_BITS);
        OFS_MASK_CLR: next_cur.mask = cur.mask & ~(bus_i.wdata & MASK_BITS);
        OFS_AREA_BASE: next_cur.area_base = bus_i.wdata & AREA_BITS;
        default: next_cur.mask = cur.mask;
      endcase
    end
    next_cur.rdata = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        OFS_FLAGS: next_cur.rdata = cur.flags;
        OFS_MASK_SET: next_cur.rdata = mask_read;
        OFS_MASK_CLR: next_cur.rdata = mask_read;
        OFS_AREA_BASE: next_cur.rdata = cur.area_base & AREA_BITS;
        OFS_PERIODIC: next_cur.rdata = cur.periodic;
        OFS_OVERRUN_CNT: next_cur.rdata = {30'h0000_0000, cur.overrun_cnt};
        default: next_cur.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur.flags <= FLAGS_RST;
      cur.mask <= MASK_RST;
      cur.area_base <= AREA_RST;
      cur.periodic <= PERIODIC_RST;
      cur.overrun_cnt <= OVERRUN_CNT_RST;
      cur.frame_msb_seen <= 1'b0;
      cur.msb_pending <= 1'b0;
      cur.resume_seen <= 1'b0;
      cur.halted <= 1'b0;
      cur.rdata <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata_o = cur.rdata;
  // Level request; drops once the flag is cleared or either enable falls
  assign host_irq_o = cur.mask[BIT_MASTER] & (|(pending & ~(32'h1 << BIT_OWNERSHIP)));
  // Ownership event goes straight to the management line, not via master enable
  assign system_management_irq_o = HAS_SMI_PIN & pending[BIT_OWNERSHIP];
  assign writeback_allowed_o = ~cur.flags[BIT_DONE_WB];
  assign processing_halt_o = cur.halted;
  assign comm_area_base_o = cur.area_base;
endmodule : uhi_irq_regs

// >>> uhi_irq_regs_asserts.sv
// Purpose: Port checks for the event flag and pointer block
// Assumes: One clock, async active-low reset
// Notes: Mask state is not a port, so it is judged through write effects
`timescale 1ns/1ps
module uhi_irq_regs_asserts (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire uhi_pkg::uhi_bus_req_t bus_i,
  input wire logic [31:0] rdata_o,
  input wire uhi_pkg::uhi_events_t events_i,
  input wire logic host_irq_o,
  input wire logic system_management_irq_o,
  input wire logic writeback_allowed_o,
  input wire logic processing_halt_o,
  input wire logic [31:0] comm_area_base_o
);
  import uhi_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_base_low_zero: assert property (comm_area_base_o[7:0] == 8'h00)
    else $error("area base low bits not zero");
  chk_base_write: assert property (bus_i.wr && bus_i.addr == OFS_AREA_BASE
    |=> comm_area_base_o == ($past(bus_i.wdata) & AREA_BITS)) else $error("area base write lost");
  chk_base_hold: assert property (!(bus_i.wr && bus_i.addr == OFS_AREA_BASE)
    |=> $stable(comm_area_base_o)) else $error("area base changed without write");
  chk_rdata_idle: assert property (!bus_i.rd |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read");
  chk_master_off: assert property (bus_i.wr && bus_i.addr == OFS_MASK_CLR
    && bus_i.wdata[31] |=> !host_irq_o) else $error("irq after master off");
  chk_smi_off: assert property (bus_i.wr && bus_i.addr == OFS_MASK_CLR
    && bus_i.wdata[30] |=> !system_management_irq_o) else $error("smi after disable");
  chk_flags_clear: assert property (bus_i.wr && bus_i.addr == OFS_FLAGS
    && bus_i.wdata == 32'hFFFF_FFFF && events_i == '0
    |=> !host_irq_o && !system_management_irq_o) else $error("irq after flag clear");
  chk_wb_block: assert property (events_i.done_writeback |=> !writeback_allowed_o)
    else $error("writeback still allowed");
  chk_halt_set: assert property (events_i.fatal_error && !events_i.error_corrected
    |=> processing_halt_o) else $error("no halt after fatal error");
endmodule : uhi_irq_regs_asserts
bind uhi_irq_regs uhi_irq_regs_asserts u_chk (.core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i), .bus_i(bus_i), .rdata_o(rdata_o), .events_i(events_i),
  .host_irq_o(host_irq_o), .system_management_irq_o(system_management_irq_o),
  .writeback_allowed_o(writeback_allowed_o), .processing_halt_o(processing_halt_o),
  .comm_area_base_o(comm_area_base_o));

// >>> uhi_irq_regs_tb_top.sv
// Purpose: Register-level tests of the event flag and pointer block
// Assumes: Event codes are packed as in the package struct, MSB first
// Notes: Levels (frame msb, resume lines) persist across pulses
`timescale 1ns/1ps
module uhi_irq_regs_tb_top;
  import uhi_pkg::*;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  uhi_bus_req_t bus = '0;
  uhi_events_t ev = '0;
  logic upd = 1'b0;
  logic [31:0] upd_addr = 32'h0000_0000;
  logic [31:0] rdata, base;
  logic irq, system_management_irq, wb_ok, halt;
  int errors = 0;
  int num_checks = 0;
  uhi_irq_regs dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bus_i(bus),
    .rdata_o(rdata), .events_i(ev), .periodic_update_i(upd), .periodic_addr_i(upd_addr),
    .host_irq_o(irq), .system_management_irq_o(system_management_irq), .writeback_allowed_o(wb_ok),
    .processing_halt_o(halt), .comm_area_base_o(base));
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_i);
    bus <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge core_clk_i);
    bus <= '0;
    #1;
    chk("rdata", e, rdata);
  endtask : rd
  // Pulse fields drop after one cycle, level fields stay
  task automatic pulse(input logic [10:0] e);
    @(posedge core_clk_i);
    ev <= e;
    @(posedge core_clk_i);
    ev <= e & 11'h118;
    #1;
  endtask : pulse
  task automatic complete_run;
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2000) @(posedge core_clk_i);
    errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 16; i += 4) rd(i[3:0], 32'h0000_0000);
    chk("wb_ok", 32'h0000_0001, {31'h0, wb_ok});
    wr(OFS_MASK_SET, 32'hFFFF_FFFF);
    rd(OFS_MASK_SET, MASK_BITS);
    wr(OFS_MASK_CLR, 32'h0000_0004);
    rd(OFS_MASK_CLR, 32'hC000_007B);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(11'h734);
    pulse(11'h1C2);
    rd(OFS_FLAGS, 32'h4000_007F);
    chk("outs", 32'hD, {28'h0, irq, system_management_irq, wb_ok, halt});
    rd(OFS_OVERRUN_CNT, 32'h0000_0001);
    repeat (3) pulse(11'h192);
    rd(OFS_OVERRUN_CNT, 32'h0000_0000);
    wr(OFS_FLAGS, 32'h0000_0000);
    rd(OFS_FLAGS, 32'h4000_007F);
    wr(OFS_FLAGS, 32'h0000_0002);
    rd(OFS_FLAGS, 32'h4000_007D);
    chk("wb_ok", 32'h1, {31'h0, wb_ok});
    wr(OFS_MASK_CLR, 32'h8000_0000);
    chk("irq smi", 32'h1, {30'h0, irq, system_management_irq});
    wr(OFS_MASK_CLR, 32'h4000_0000);
    pulse(11'h111);
    chk("smi halt", 32'h0, {30'h0, system_management_irq, halt});
    pulse(11'h000);
    wr(OFS_FLAGS, 32'hFFFF_FFFF);
    pulse(11'h018);
    pulse(11'h000);
    rd(OFS_FLAGS, 32'h0000_0000);
    pulse(11'h010);
    rd(OFS_FLAGS, 32'h0000_0008);
    wr(OFS_AREA_BASE, 32'hFFFF_FFFF);
    rd(OFS_AREA_BASE, 32'hFFFF_FF00);
    chk("base", 32'hFFFF_FF00, base);
    wr(OFS_PERIODIC, 32'hFFFF_FFFF);
    rd(OFS_PERIODIC, 32'h0000_0000);
    upd <= 1'b1;
    upd_addr <= 32'h1234_5678;
    @(posedge core_clk_i);
    upd <= 1'b0;
    rd(OFS_PERIODIC, 32'h1234_5670);
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, 32'h0000_0000);
    complete_run();
  end
endmodule : uhi_irq_regs_tb_top
